/* gpmx_pkg.sv */
// Package of constants and carrier types for the pin function mux
package gpmx_pkg;

	// ****************************************
	// Port widths
	// ****************************************
	localparam int unsigned PORT_A_W = 12; // Port A bits
	localparam int unsigned PORT_B_W = 8; // Port B bits
	localparam int unsigned PORT_C_W = 7; // Port C bits

	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_A_PULLUP = 8'h00; // Port A pull-up enables
	localparam logic [7:0] OFS_A_PERIPH = 8'h04; // Port A peripheral enables
	localparam logic [7:0] OFS_B_PULLUP = 8'h08; // Port B pull-up enables
	localparam logic [7:0] OFS_B_PERIPH = 8'h0c; // Port B peripheral enables
	localparam logic [7:0] OFS_C_PULLUP = 8'h10; // Port C pull-up enables
	localparam logic [7:0] OFS_C_PERIPH = 8'h14; // Port C peripheral enables
	localparam logic [7:0] OFS_PIN_SEL = 8'h18; // Peripheral pin select
	localparam logic [7:0] OFS_DEC_CTRL = 8'h1c; // Decoder control
	localparam logic [7:0] OFS_STATUS = 8'h20; // Pad mode status, read only

	// ****************************************
	// Field positions
	// ****************************************
	localparam int unsigned SEL_A_LSB = 0; // Port A bits 2..5 select, 4 bits
	localparam int unsigned SEL_C_LSB = 4; // Port C bits 5..6 select, 2 bits
	localparam int unsigned SEL_W = 6; // Used width of pin select reg
	localparam int unsigned DEC_TMR_BIT = 0; // Decoder control: 1 = timer A on pads
	localparam int unsigned DEC_W = 1; // Used width of decoder control reg

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [11:0] RST_A_PULLUP = 12'hfff; // Pull-ups on for port A
	localparam logic [11:0] RST_A_PERIPH = 12'hfff; // Modulator on at reset
	localparam logic [7:0] RST_B_PULLUP = 8'hff; // Pull-ups on for port B
	localparam logic [7:0] RST_B_PERIPH = 8'hff; // Serial 0 and decoder on
	localparam logic [6:0] RST_C_PULLUP = 7'h7c; // Crystal pads off
	localparam logic [6:0] RST_C_PERIPH = 7'h7f; // Crystal, CAN, timer C on every pad
	localparam logic [5:0] RST_PIN_SEL = 6'h00; // Modulator and timer C
	localparam logic [0:0] RST_DEC_CTRL = 1'h0; // Decoder on pads

	// ****************************************
	// Carrier types
	// ****************************************
	// Wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} gpmx_wb_req_s;

	// Pad side of one port
	typedef struct packed {
		logic [11:0] out;
		logic [11:0] oe;
		logic [11:0] pull;
	} gpmx_pad_drv_s;

	// Selects that steer the muxes
	typedef struct packed {
		logic [3:0] a_spi; // 1 = second serial port on A2..A5
		logic [1:0] c_sci; // 1 = serial port 0 on C5..C6
		logic b_tmr; // 1 = timer A on B4..B7
	} gpmx_sel_s;

endpackage

/* gpmx_sync.sv */
// Two-flop synchroniser for the pad inputs
`timescale 1ns/10ps
module gpmx_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	// ****************************************
	// Two stages, the first read only by the second
	// ****************************************
	logic [W-1:0] meta; // First stage
	logic [W-1:0] next_meta; // First stage next
	logic [W-1:0] next_q; // Second stage next

	// Next values
	always_comb
	begin
		next_meta = d;
		next_q = meta;
		if (srst)
		begin
			next_meta = '0;
			next_q = '0;
		end
	end

	// Register both stages
	always_ff @(posedge clk)
	begin
		meta <= next_meta;
		q <= next_q;
	end

endmodule

/* gpmx_port.sv */
// One port's pad mux: port bit or peripheral per pin
`timescale 1ns/10ps
module gpmx_port #(
	parameter int unsigned W = 8
) (
	input wire logic [W-1:0] periph_en,
	input wire logic [W-1:0] port_out,
	input wire logic [W-1:0] port_oe,
	input wire logic [W-1:0] func_out,
	input wire logic [W-1:0] func_oe,
	input wire logic [W-1:0] func_ok,
	output logic [W-1:0] pad_out,
	output logic [W-1:0] pad_oe
);

	// ****************************************
	// Per-pin choice
	// ****************************************
	// A pad whose function is absent falls back to the port
	always_comb
	begin
		for (int i = 0; i < W; i++)
		begin
			if (periph_en[i] && func_ok[i])
			begin
				pad_out[i] = func_out[i];
				pad_oe[i] = func_oe[i];
			end
			else
			begin
				pad_out[i] = port_out[i];
				pad_oe[i] = port_oe[i];
			end
		end
	end

endmodule

/* gpmx_top.sv */
// Pin function mux for ports A, B and C with Wishbone registers
//
// Behaviour
// - A2..A5 select second serial port or modulator
// - B4..B7 decoder inputs or timer A channels
// - C5..C6 timer C or serial port zero
// - Crystal pad pull-ups disabled after reset
// - Registers hold only port-width bits
// - Per-port reset values follow default functions
// - Reduced variant lacks modulator, CAN, decoder
// - Ports A, B, C are 12, 8, 7 bits
// - Reset defaults: modulator, serial 0/decoder, crystal/CAN/timer
`timescale 1ns/10ps
module gpmx_top #(
	parameter bit REDUCED = 1'b0
) (
	input wire logic clk,
	input wire logic srst,
	// Wishbone slave
	input wire gpmx_pkg::gpmx_wb_req_s wb_req,
	output logic [31:0] wb_dat_o,
	output logic wb_ack,
	// Port logic, per bit
	input wire logic [11:0] port_a_bit_out,
	input wire logic [11:0] port_a_bit_oe,
	output logic [11:0] port_a_bit_in,
	input wire logic [7:0] port_b_bit_out,
	input wire logic [7:0] port_b_bit_oe,
	output logic [7:0] port_b_bit_in,
	input wire logic [6:0] port_c_bit_out,
	input wire logic [6:0] port_c_bit_oe,
	output logic [6:0] port_c_bit_in,
	// Modulator A outputs 0..5, fault and current sense inputs
	input wire logic [5:0] pwm_out,
	output logic [2:0] modulator_fault_input,
	output logic [2:0] current_sense_input,
	// Second serial port: ss, miso, mosi, sclk
	input wire logic [3:0] second_serial_periph_port_out,
	input wire logic [3:0] second_serial_periph_port_oe,
	output logic [3:0] second_serial_periph_port_in,
	// First serial port: ss, miso, mosi, sclk
	input wire logic [3:0] first_serial_periph_port_out,
	input wire logic [3:0] first_serial_periph_port_oe,
	output logic [3:0] first_serial_periph_port_in,
	// Decoder: home, index, phase b, phase a
	output logic [3:0] decoder_in,
	// Timer A channels 3..0 on B4..B7
	input wire logic [3:0] timer_a_channel_out,
	input wire logic [3:0] timer_a_channel_oe,
	output logic [3:0] timer_a_channel_in,
	// Timer C channels 0, 1, 2
	input wire logic [2:0] timer_c_channel_out,
	input wire logic [2:0] timer_c_channel_oe,
	output logic [2:0] timer_c_channel_in,
	// Serial port zero
	input wire logic serial_transmit_line,
	output logic serial_receive_line,
	// CAN
	input wire logic can_tx,
	output logic can_rx,
	// Pads
	input wire logic [11:0] pad_a_in,
	output logic [11:0] pad_a_out,
	output logic [11:0] pad_a_oe,
	output logic [11:0] pad_a_pull,
	input wire logic [7:0] pad_b_in,
	output logic [7:0] pad_b_out,
	output logic [7:0] pad_b_oe,
	output logic [7:0] pad_b_pull,
	input wire logic [6:0] pad_c_in,
	output logic [6:0] pad_c_out,
	output logic [6:0] pad_c_oe,
	output logic [6:0] pad_c_pull,
	// Crystal pads handed to the oscillator when selected
	output logic crystal_enable
);

	// ****************************************
	// Register state
	// ****************************************
	logic [11:0] a_pullup; // Port A pull-ups
	logic [11:0] a_periph; // Port A peripheral enables
	logic [7:0] b_pullup; // Port B pull-ups
	logic [7:0] b_periph; // Port B peripheral enables
	logic [6:0] c_pullup; // Port C pull-ups
	logic [6:0] c_periph; // Port C peripheral enables
	logic [5:0] peripheral_pin_select_reg; // Mux selects
	logic [0:0] decoder_control_reg; // Decoder or timer A
	logic [11:0] next_a_pullup;
	logic [11:0] next_a_periph;
	logic [7:0] next_b_pullup;
	logic [7:0] next_b_periph;
	logic [6:0] next_c_pullup;
	logic [6:0] next_c_periph;
	logic [5:0] next_sel;
	logic [0:0] next_dec;
	logic next_ack;
	logic [31:0] next_dat;
	logic req; // Live request not yet answered
	logic wr; // Write strobe for this cycle
	gpmx_pkg::gpmx_sel_s sel; // Decoded selects

	// Byte-lane merge, used for every register
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	// ****************************************
	// Wishbone slave: registered ack one cycle after the request, then drop
	// ****************************************
	assign req = wb_req.cyc && wb_req.stb && !wb_ack;
	assign wr = wb_req.cyc && wb_req.stb && wb_ack && wb_req.we; // Commit on the edge the master sees ack

	// Next register values
	always_comb
	begin
		next_a_pullup = a_pullup;
		next_a_periph = a_periph;
		next_b_pullup = b_pullup;
		next_b_periph = b_periph;
		next_c_pullup = c_pullup;
		next_c_periph = c_periph;
		next_sel = peripheral_pin_select_reg;
		next_dec = decoder_control_reg;
		next_ack = req;
		next_dat = 32'h0000_0000;
		// Upper bits never stored, widths cut the merge
		if (wr)
		begin
			unique case (wb_req.adr)
				gpmx_pkg::OFS_A_PULLUP: next_a_pullup = 12'(lane_merge({20'h0, a_pullup}, wb_req.dat, wb_req.sel));
				gpmx_pkg::OFS_A_PERIPH: next_a_periph = 12'(lane_merge({20'h0, a_periph}, wb_req.dat, wb_req.sel));
				gpmx_pkg::OFS_B_PULLUP: next_b_pullup = 8'(lane_merge({24'h0, b_pullup}, wb_req.dat, wb_req.sel));
				gpmx_pkg::OFS_B_PERIPH: next_b_periph = 8'(lane_merge({24'h0, b_periph}, wb_req.dat, wb_req.sel));
				gpmx_pkg::OFS_C_PULLUP: next_c_pullup = 7'(lane_merge({25'h0, c_pullup}, wb_req.dat, wb_req.sel));
				gpmx_pkg::OFS_C_PERIPH: next_c_periph = 7'(lane_merge({25'h0, c_periph}, wb_req.dat, wb_req.sel));
				gpmx_pkg::OFS_PIN_SEL: next_sel = 6'(lane_merge({26'h0, peripheral_pin_select_reg}, wb_req.dat, wb_req.sel));
				gpmx_pkg::OFS_DEC_CTRL: next_dec = 1'(lane_merge({31'h0, decoder_control_reg}, wb_req.dat, wb_req.sel));
				default: ; // Unmapped or read-only: write ignored, still acked
			endcase
		end
		// Read data, zero above each port width
		if (req && !wb_req.we)
		begin
			unique case (wb_req.adr)
				gpmx_pkg::OFS_A_PULLUP: next_dat = {20'h0, a_pullup};
				gpmx_pkg::OFS_A_PERIPH: next_dat = {20'h0, a_periph};
				gpmx_pkg::OFS_B_PULLUP: next_dat = {24'h0, b_pullup};
				gpmx_pkg::OFS_B_PERIPH: next_dat = {24'h0, b_periph};
				gpmx_pkg::OFS_C_PULLUP: next_dat = {25'h0, c_pullup};
				gpmx_pkg::OFS_C_PERIPH: next_dat = {25'h0, c_periph};
				gpmx_pkg::OFS_PIN_SEL: next_dat = {26'h0, peripheral_pin_select_reg};
				gpmx_pkg::OFS_DEC_CTRL: next_dat = {31'h0, decoder_control_reg};
				gpmx_pkg::OFS_STATUS: next_dat = {24'h0, crystal_enable, REDUCED, sel.b_tmr, sel.c_sci, 3'h0};
				default: next_dat = 32'h0000_0000; // Unmapped reads as zero
			endcase
		end
		// Per-port reset values from each pin's default function
		if (srst)
		begin
			next_a_pullup = gpmx_pkg::RST_A_PULLUP;
			next_a_periph = gpmx_pkg::RST_A_PERIPH;
			next_b_pullup = gpmx_pkg::RST_B_PULLUP;
			next_b_periph = gpmx_pkg::RST_B_PERIPH;
			next_c_pullup = gpmx_pkg::RST_C_PULLUP;
			next_c_periph = gpmx_pkg::RST_C_PERIPH;
			next_sel = gpmx_pkg::RST_PIN_SEL;
			next_dec = gpmx_pkg::RST_DEC_CTRL;
			next_ack = 1'b0;
			next_dat = 32'h0000_0000;
		end
	end

	// Register the bus state
	always_ff @(posedge clk)
	begin
		a_pullup <= next_a_pullup;
		a_periph <= next_a_periph;
		b_pullup <= next_b_pullup;
		b_periph <= next_b_periph;
		c_pullup <= next_c_pullup;
		c_periph <= next_c_periph;
		peripheral_pin_select_reg <= next_sel;
		decoder_control_reg <= next_dec;
		wb_ack <= next_ack;
		wb_dat_o <= next_dat;
	end

	// ****************************************
	// Select decode
	// ****************************************
	always_comb
	begin
		sel.a_spi = peripheral_pin_select_reg[gpmx_pkg::SEL_A_LSB +: 4];
		sel.c_sci = peripheral_pin_select_reg[gpmx_pkg::SEL_C_LSB +: 2];
		sel.b_tmr = decoder_control_reg[gpmx_pkg::DEC_TMR_BIT];
		// Reduced part has no modulator or decoder: force the alternatives
		if (REDUCED)
		begin
			sel.a_spi = 4'hf;
			sel.b_tmr = 1'b1;
		end
	end

	// ****************************************
	// Synchronised pad inputs
	// ****************************************
	logic [11:0] a_in; // Port A pad inputs after two flops
	logic [7:0] b_in; // Port B pad inputs after two flops
	logic [6:0] c_in; // Port C pad inputs after two flops

	gpmx_sync #(.W(gpmx_pkg::PORT_A_W)) u_sync_a (.clk(clk), .srst(srst), .d(pad_a_in), .q(a_in));
	gpmx_sync #(.W(gpmx_pkg::PORT_B_W)) u_sync_b (.clk(clk), .srst(srst), .d(pad_b_in), .q(b_in));
	gpmx_sync #(.W(gpmx_pkg::PORT_C_W)) u_sync_c (.clk(clk), .srst(srst), .d(pad_c_in), .q(c_in));

	// ****************************************
	// Peripheral function per pad
	// ****************************************
	logic [11:0] a_fo; // Port A function outputs
	logic [11:0] a_fe; // Port A function enables
	logic [11:0] a_ok; // Port A function present
	logic [7:0] b_fo;
	logic [7:0] b_fe;
	logic [7:0] b_ok;
	logic [6:0] c_fo;
	logic [6:0] c_fe;
	logic [6:0] c_ok;

	// Outbound functions, per pad
	always_comb
	begin
		// Port A: modulator 0..1, shared 2..5, inputs 6..11
		a_fo = '0;
		a_fe = '0;
		a_fo[1:0] = pwm_out[1:0];
		a_fe[1:0] = 2'h3;
		for (int i = 0; i < 4; i++)
		begin
			a_fo[2+i] = sel.a_spi[i] ? second_serial_periph_port_out[i] : pwm_out[2+i];
			a_fe[2+i] = sel.a_spi[i] ? second_serial_periph_port_oe[i] : 1'b1;
		end
		a_ok = {6'h3f, 4'hf, {2{!REDUCED}}};
		a_ok[11:6] = {6{!REDUCED}};
		// Port B: first serial port 0..3, decoder/timer 4..7
		b_fo = '0;
		b_fe = '0;
		b_fo[3:0] = first_serial_periph_port_out;
		b_fe[3:0] = first_serial_periph_port_oe;
		for (int i = 0; i < 4; i++)
		begin
			b_fo[4+i] = timer_a_channel_out[3-i];
			b_fe[4+i] = sel.b_tmr & timer_a_channel_oe[3-i];
		end
		b_ok = 8'hff;
		// Port C: crystal 0..1, CAN 2..3, timer C 4..6
		c_fo = '0;
		c_fe = '0;
		c_fo[3] = can_tx;
		c_fe[3] = 1'b1;
		c_fo[4] = timer_c_channel_out[2];
		c_fe[4] = timer_c_channel_oe[2];
		c_fo[5] = sel.c_sci[0] ? 1'b0 : timer_c_channel_out[1];
		c_fe[5] = sel.c_sci[0] ? 1'b0 : timer_c_channel_oe[1];
		c_fo[6] = sel.c_sci[1] ? serial_transmit_line : timer_c_channel_out[0];
		c_fe[6] = sel.c_sci[1] ? 1'b1 : timer_c_channel_oe[0];
		c_ok = {5'h1f, 2'h3};
		c_ok[3:2] = {2{!REDUCED}};
	end

	// Inbound functions, only from pads given to the peripheral
	always_comb
	begin
		modulator_fault_input = a_in[8:6] & a_periph[8:6] & {3{!REDUCED}};
		current_sense_input = a_in[11:9] & a_periph[11:9] & {3{!REDUCED}};
		second_serial_periph_port_in = a_in[5:2] & a_periph[5:2] & sel.a_spi;
		first_serial_periph_port_in = b_in[3:0] & b_periph[3:0];
		for (int i = 0; i < 4; i++)
		begin
			decoder_in[i] = b_in[4+i] & b_periph[4+i] & !sel.b_tmr;
			timer_a_channel_in[3-i] = b_in[4+i] & b_periph[4+i] & sel.b_tmr;
		end
		can_rx = c_in[2] & c_periph[2] & !REDUCED;
		timer_c_channel_in[2] = c_in[4] & c_periph[4];
		timer_c_channel_in[1] = c_in[5] & c_periph[5] & !sel.c_sci[0];
		timer_c_channel_in[0] = c_in[6] & c_periph[6] & !sel.c_sci[1];
		serial_receive_line = c_in[5] & c_periph[5] & sel.c_sci[0];
		crystal_enable = c_periph[0] & c_periph[1];
		port_a_bit_in = a_in;
		port_b_bit_in = b_in;
		port_c_bit_in = c_in;
		pad_a_pull = a_pullup;
		pad_b_pull = b_pullup;
		pad_c_pull = c_pullup;
	end

	// ****************************************
	// Pad muxes, one per port
	// ****************************************
	gpmx_port #(.W(gpmx_pkg::PORT_A_W)) u_port_a (
		.periph_en(a_periph),
		.port_out(port_a_bit_out),
		.port_oe(port_a_bit_oe),
		.func_out(a_fo),
		.func_oe(a_fe),
		.func_ok(a_ok),
		.pad_out(pad_a_out),
		.pad_oe(pad_a_oe)
	);

	gpmx_port #(.W(gpmx_pkg::PORT_B_W)) u_port_b (
		.periph_en(b_periph),
		.port_out(port_b_bit_out),
		.port_oe(port_b_bit_oe),
		.func_out(b_fo),
		.func_oe(b_fe),
		.func_ok(b_ok),
		.pad_out(pad_b_out),
		.pad_oe(pad_b_oe)
	);

	// Crystal pads never driven digitally while the peripheral owns them
	gpmx_port #(.W(gpmx_pkg::PORT_C_W)) u_port_c (
		.periph_en(c_periph),
		.port_out(port_c_bit_out),
		.port_oe(port_c_bit_oe),
		.func_out(c_fo),
		.func_oe(c_fe),
		.func_ok(c_ok),
		.pad_out(pad_c_out),
		.pad_oe(pad_c_oe)
	);

endmodule

/* gpmx_top_monitor.sv */
// Port checker for the pin function mux
`timescale 1ns/10ps
module gpmx_top_monitor (
	input wire logic clk,
	input wire logic srst,
	input wire gpmx_pkg::gpmx_wb_req_s wb_req,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack,
	input wire logic [11:0] pad_a_in,
	input wire logic [11:0] pad_a_pull,
	input wire logic [7:0] pad_b_in,
	input wire logic [6:0] pad_c_in,
	input wire logic [6:0] pad_c_pull,
	input wire logic [2:0] modulator_fault_input,
	input wire logic [2:0] current_sense_input,
	input wire logic [3:0] decoder_in,
	input wire logic serial_receive_line,
	input wire logic can_rx
);
	// One clock domain, reset disables every check
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// ****************************************
	// Bus handshake
	// ****************************************
	// Request seen and not yet answered
	sequence s_take;
		wb_req.cyc && wb_req.stb && !wb_ack;
	endsequence
	// Read answer on the bus
	sequence s_read_ack;
		wb_ack && !wb_req.we;
	endsequence
	property p_ack_one;
		s_take |=> wb_ack;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("bus answer missing");
	property p_ack_drop;
		wb_ack |=> !wb_ack;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("bus answer held too long");
	property p_ack_cause;
		!(wb_req.cyc && wb_req.stb) |=> !wb_ack;
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("bus answer without request");
	// Narrow port: upper bits never read back
	property p_width_c;
		s_read_ack ##0 (wb_req.adr == gpmx_pkg::OFS_C_PULLUP) |-> wb_dat_o[31:7] == 25'h0;
	endproperty
	a_width_c: assert property (p_width_c) else $error("port c reads above width");
	property p_unmapped;
		s_read_ack ##0 (wb_req.adr == 8'h24) |-> wb_dat_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	// ****************************************
	// Reset defaults and input routing
	// ****************************************
	property p_crystal_output_pull;
		$fell(srst) |-> pad_c_pull[1:0] == 2'h0;
	endproperty
	a_crystal_output_pull: assert property (p_crystal_output_pull) else $error("crystal pulls on after reset");
	property p_a_pull;
		$fell(srst) |-> pad_a_pull == gpmx_pkg::RST_A_PULLUP;
	endproperty
	a_a_pull: assert property (p_a_pull) else $error("port a pulls wrong after reset");
	// A routed input is high only if its pad was high two edges earlier
	property p_fault;
		(modulator_fault_input & ~$past(pad_a_in[8:6], 2)) == 3'h0;
	endproperty
	a_fault: assert property (p_fault) else $error("fault input not from a6..a8");
	property p_sense;
		(current_sense_input & ~$past(pad_a_in[11:9], 2)) == 3'h0;
	endproperty
	a_sense: assert property (p_sense) else $error("sense input not from a9..a11");
	property p_decoder;
		(decoder_in & ~$past(pad_b_in[7:4], 2)) == 4'h0;
	endproperty
	a_decoder: assert property (p_decoder) else $error("decoder input not from b4..b7");
	property p_rx;
		serial_receive_line |-> $past(pad_c_in[5], 2);
	endproperty
	a_rx: assert property (p_rx) else $error("receive line not from c5");
	property p_can;
		can_rx |-> $past(pad_c_in[2], 2);
	endproperty
	a_can: assert property (p_can) else $error("can receive not from c2");
endmodule
bind gpmx_top gpmx_top_monitor u_mon (.clk(clk), .srst(srst), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
	.wb_ack(wb_ack), .pad_a_in(pad_a_in), .pad_a_pull(pad_a_pull), .pad_b_in(pad_b_in), .pad_c_in(pad_c_in),
	.pad_c_pull(pad_c_pull), .modulator_fault_input(modulator_fault_input),
	.current_sense_input(current_sense_input), .decoder_in(decoder_in),
	.serial_receive_line(serial_receive_line), .can_rx(can_rx));

/* gpmx_pad_model.sv */
// Board side of one port: pads seen from outside the chip
`timescale 1ns/10ps
module gpmx_pad_model #(
	parameter int unsigned W = 8
) (
	input wire logic clk,
	input wire logic [W-1:0] pad_out,
	input wire logic [W-1:0] pad_oe,
	input wire logic [W-1:0] pad_pull,
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_val,
	output logic [W-1:0] pad_in
);
	logic [W-1:0] churn; // Floating level, flips each cycle so it never looks stable
	initial churn = '0;
	// Undriven pads wander rather than settle to a kind value
	always @(posedge clk)
		churn <= ~churn;
	// Chip drive wins, then board drive, then pull-up, else floating
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & (pad_pull | churn));
endmodule

/* tb_gpio_pin_function_mux.sv */
// Self-checking bench of the pin function mux
`timescale 1ns/10ps
module tb_gpio_pin_function_mux;
	logic clk, srst, wb_ack, serial_transmit_line, serial_receive_line, can_tx, can_rx, crystal_enable;
	gpmx_pkg::gpmx_wb_req_s wb_req;
	logic [31:0] wb_dat_o;
	logic [11:0] port_a_bit_out, port_a_bit_oe, port_a_bit_in, pad_a_in, pad_a_out, pad_a_oe, pad_a_pull;
	logic [7:0] port_b_bit_out, port_b_bit_oe, port_b_bit_in, pad_b_in, pad_b_out, pad_b_oe, pad_b_pull;
	logic [6:0] port_c_bit_out, port_c_bit_oe, port_c_bit_in, pad_c_in, pad_c_out, pad_c_oe, pad_c_pull;
	logic [5:0] pwm_out;
	logic [3:0] second_serial_periph_port_out, second_serial_periph_port_oe, second_serial_periph_port_in, first_serial_periph_port_out, first_serial_periph_port_oe, first_serial_periph_port_in, decoder_in;
	logic [3:0] timer_a_channel_out, timer_a_channel_oe, timer_a_channel_in;
	logic [2:0] modulator_fault_input, current_sense_input, timer_c_channel_out, timer_c_channel_oe;
	logic [2:0] timer_c_channel_in;
	logic [7:0] ext_b_en, ext_b_val; // Board drive on port B
	logic [11:0] ext_a_en, ext_a_val; // Board drive on port A
	logic [6:0] ext_c_en, ext_c_val; // Board drive on port C
	int n_fail, n_tests;
	gpmx_top #(.REDUCED(1'b0)) DUT (.clk, .srst, .wb_req, .wb_dat_o, .wb_ack,
		.port_a_bit_out, .port_a_bit_oe, .port_a_bit_in, .port_b_bit_out, .port_b_bit_oe, .port_b_bit_in,
		.port_c_bit_out, .port_c_bit_oe, .port_c_bit_in, .pwm_out, .modulator_fault_input, .current_sense_input,
		.second_serial_periph_port_out, .second_serial_periph_port_oe, .second_serial_periph_port_in, .first_serial_periph_port_out, .first_serial_periph_port_oe, .first_serial_periph_port_in, .decoder_in, .timer_a_channel_out,
		.timer_a_channel_oe, .timer_a_channel_in, .timer_c_channel_out, .timer_c_channel_oe, .timer_c_channel_in,
		.serial_transmit_line, .serial_receive_line, .can_tx, .can_rx, .pad_a_in, .pad_a_out, .pad_a_oe,
		.pad_a_pull, .pad_b_in, .pad_b_out, .pad_b_oe, .pad_b_pull, .pad_c_in, .pad_c_out, .pad_c_oe,
		.pad_c_pull, .crystal_enable);
	gpmx_pad_model #(.W(12)) u_pad_a (.clk(clk), .pad_out(pad_a_out), .pad_oe(pad_a_oe), .pad_pull(pad_a_pull),
		.ext_en(ext_a_en), .ext_val(ext_a_val), .pad_in(pad_a_in));
	gpmx_pad_model #(.W(8)) u_pad_b (.clk(clk), .pad_out(pad_b_out), .pad_oe(pad_b_oe), .pad_pull(pad_b_pull),
		.ext_en(ext_b_en), .ext_val(ext_b_val), .pad_in(pad_b_in));
	gpmx_pad_model #(.W(7)) u_pad_c (.clk(clk), .pad_out(pad_c_out), .pad_oe(pad_c_oe), .pad_pull(pad_c_pull),
		.ext_en(ext_c_en), .ext_val(ext_c_val), .pad_in(pad_c_in));
	// ****************************************
	// Shared tasks
	// ****************************************
	// Compare and count; unknowns never match
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// Classic cycle: hold everything until ack is sampled, then release for a cycle
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
		do
		begin
			@(posedge clk);
		end
		while (wb_ack !== 1'b1);
		q = wb_dat_o;
		wb_req <= '0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] q;
		wb_xfer(1'b1, adr, d, q);
	endtask
	task automatic rchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] q;
		wb_xfer(1'b0, adr, 32'h0, q);
		chk(what, exp, q);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	// Defaults straight out of reset
	task t_reset_values();
		rchk("a pull", gpmx_pkg::OFS_A_PULLUP, 32'(gpmx_pkg::RST_A_PULLUP));
		rchk("a periph", gpmx_pkg::OFS_A_PERIPH, 32'(gpmx_pkg::RST_A_PERIPH));
		rchk("b periph", gpmx_pkg::OFS_B_PERIPH, 32'(gpmx_pkg::RST_B_PERIPH));
		rchk("c pull", gpmx_pkg::OFS_C_PULLUP, 32'(gpmx_pkg::RST_C_PULLUP));
		rchk("c periph", gpmx_pkg::OFS_C_PERIPH, 32'(gpmx_pkg::RST_C_PERIPH));
		chk("crystal pulls", 32'h0, 32'(pad_c_pull[1:0]));
		chk("crystal enable", 32'h1, 32'(crystal_enable));
		$display("reset value test done");
	endtask
	// Writes of all ones keep only the port width
	task t_width();
		wr(gpmx_pkg::OFS_A_PULLUP, 32'hffffffff);
		wr(gpmx_pkg::OFS_B_PULLUP, 32'hffffffff);
		wr(gpmx_pkg::OFS_C_PULLUP, 32'hffffffff);
		rchk("a width", gpmx_pkg::OFS_A_PULLUP, 32'h00000fff);
		rchk("b width", gpmx_pkg::OFS_B_PULLUP, 32'h000000ff);
		rchk("c width", gpmx_pkg::OFS_C_PULLUP, 32'h0000007f);
		rchk("unmapped", 8'h24, 32'h0);
		wr(gpmx_pkg::OFS_C_PULLUP, 32'h0);
		$display("width test done");
	endtask
	// Per-pin choice on A2..A5 and C5/C6
	task t_pin_select();
		second_serial_periph_port_out <= 4'hf;
		ext_c_en <= 7'h20;
		ext_c_val <= 7'h20;
		serial_transmit_line <= 1'b1;
		wr(gpmx_pkg::OFS_PIN_SEL, 32'h0);
		chk("a2..a5 modulator", 32'h0, 32'(pad_a_out[5:2]));
		chk("c5 timer in", 32'h1, 32'(timer_c_channel_in[1]));
		chk("c5 receive idle", 32'h0, 32'(serial_receive_line));
		wr(gpmx_pkg::OFS_PIN_SEL, 32'h5);
		chk("a2..a5 per pin", 32'h5, 32'(pad_a_out[5:2]));
		wr(gpmx_pkg::OFS_PIN_SEL, 32'h20);
		chk("c6 transmit", 32'h1, 32'(pad_c_out[6]));
		wr(gpmx_pkg::OFS_PIN_SEL, 32'h10);
		chk("c5 receive", 32'h1, 32'(serial_receive_line));
		wr(gpmx_pkg::OFS_PIN_SEL, 32'h0);
		$display("pin select test done");
	endtask
	// B4..B7 between decoder inputs and timer A channels 3..0
	task t_decoder();
		timer_a_channel_out <= 4'h8;
		ext_b_en <= 8'hf0;
		ext_b_val <= 8'h10;
		wr(gpmx_pkg::OFS_DEC_CTRL, 32'h0);
		chk("decoder in", 32'h1, 32'(decoder_in));
		wr(gpmx_pkg::OFS_DEC_CTRL, 32'h1);
		chk("timer a out", 32'h1, 32'(pad_b_out[7:4]));
		chk("timer a in", 32'h8, 32'(timer_a_channel_in));
		chk("decoder off", 32'h0, 32'(decoder_in));
		wr(gpmx_pkg::OFS_DEC_CTRL, 32'h0);
		$display("decoder test done");
	endtask
	// Fixed CAN and modulator input pads, then port A logic once the port A peripheral enables are off
	task t_fixed();
		can_tx <= 1'b1;
		ext_a_en <= 12'h1c0;
		ext_a_val <= 12'h040;
		ext_c_en <= 7'h04;
		ext_c_val <= 7'h04;
		repeat (3) @(posedge clk);
		chk("c3 can out", 32'h1, 32'(pad_c_out[3]));
		chk("c3 can drive", 32'h1, 32'(pad_c_oe[3]));
		chk("c2 can in", 32'h1, 32'(can_rx));
		chk("a6..a8 fault in", 32'h1, 32'(modulator_fault_input));
		chk("a9..a11 sense in", 32'h7, 32'(current_sense_input));
		wr(gpmx_pkg::OFS_A_PERIPH, 32'h0);
		chk("a port logic", 32'h00000a5a, 32'(pad_a_out));
		chk("a6..a8 fault off", 32'h0, 32'(modulator_fault_input));
		wr(gpmx_pkg::OFS_A_PERIPH, 32'h00000fff);
		$display("fixed pad test done");
	endtask
	// Verdict, reached by the tests or the watchdog
	task finish_test();
		$display("comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ****************************************
	// Clock, main sequence, watchdog
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		n_fail = 0;
		n_tests = 0;
		srst = 1'b1;
		wb_req = '0;
		port_a_bit_out = 12'ha5a;
		port_a_bit_oe = 12'hfff;
		{port_b_bit_out, port_b_bit_oe, port_c_bit_out, port_c_bit_oe, pwm_out, first_serial_periph_port_out, first_serial_periph_port_oe} = '0;
		{second_serial_periph_port_out, second_serial_periph_port_oe, timer_a_channel_out, timer_a_channel_oe, timer_c_channel_out, timer_c_channel_oe} = '0;
		{serial_transmit_line, can_tx, ext_a_en, ext_a_val, ext_b_en, ext_b_val, ext_c_en, ext_c_val} = '0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		t_reset_values();
		t_width();
		t_pin_select();
		t_decoder();
		t_fixed();
		finish_test();
	end
	// Tests need about 80 cycles; this cuts a hang short
	initial
	begin
		repeat (5000) @(posedge clk);
		n_fail++;
		$display("watchdog expired");
		finish_test();
	end
endmodule
